// ==== hw/ssm_pkg.sv ====
// package for the shared serial port multiplexer: mode encodings and carrier structs
// assumes one peripheral clock; select bits come from system control logic on that clock
package ssm_pkg;

  // which unit owns the five shared pads
  typedef enum logic [1:0] {
    SSM_MODE_SYNC = 2'b00,
    SSM_MODE_TEL = 2'b01,
    SSM_MODE_MM = 2'b11
  } ssm_mode_e;

  localparam logic SSM_SERIAL_UNIT_SELECT_BIT_RESET = 1'b0;
  localparam logic SSM_CPSEL_RESET = 1'b0;
  localparam logic SSM_MODE_RESET_IS_SYNC = 1'b1;
  localparam int SSM_SYNC_STAGES = 2;

  // unit side outputs toward the pads
  typedef struct packed {
    logic bit_clock;
    logic data_out;
    logic frame;
  } ssm_unit_tx_s;

  // sync serial unit extra drive controls (master role)
  typedef struct packed {
    logic bit_clock_oe;
    logic tx_frame_oe;
    logic rx_frame;
    logic rx_frame_oe;
  } ssm_sync_ctl_s;

  // receive side delivered to a unit
  typedef struct packed {
    logic bit_clock;
    logic data_in;
    logic tx_frame;
    logic rx_frame;
  } ssm_unit_rx_s;

  // pad output bundle: value and enable per pad
  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic txd_o;
    logic txd_oe;
    logic txfr_o;
    logic txfr_oe;
    logic rxfr_o;
    logic rxfr_oe;
  } ssm_pad_out_s;

endpackage : ssm_pkg

// ==== hw/ssm_mux.sv ====
// shared serial port multiplexer: places one of three serial units onto five shared pads
// assumes pads are resolved outside (pull-up on the rx frame pad); unit signals are on mclk
// assumes a pad output enable is high while this block drives that pad
// assumes the select bits are settled system control state on mclk
`timescale 1ns/1ps

// Overview of operation
// - serial unit select bit chooses sync serial unit or telephony unit
// - codec port select bit chooses the multimedia port over the other two
// - exactly one unit owns the pads; others neither drive nor sample them
// - bit clock pad outputs multimedia or telephony clock; bidirectional in sync mode
// - tx data pad carries the selected unit's transmit data
// - rx data pad is routed only to the selected unit
// - tx frame pad outputs sample clock or frame sync; bidirectional in sync mode
// - rx frame pad used only in sync mode; otherwise undriven, held by pull-up
// - sync mode supports master driving clock and frames, slave receiving them
module ssm_mux
  import ssm_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic serial_unit_select_bit,
  input wire logic codec_port_select_bit,
  input wire ssm_unit_tx_s multimedia_tx,
  input wire ssm_unit_tx_s telephony_tx,
  input wire ssm_unit_tx_s sync_tx,
  input wire ssm_sync_ctl_s sync_ctl,
  input wire logic bit_clock_pad_i,
  input wire logic rx_data_pad_i,
  input wire logic tx_frame_pad_i,
  input wire logic rx_frame_pad_i,
  output ssm_pad_out_s pads,
  output ssm_unit_rx_s multimedia_rx,
  output ssm_unit_rx_s telephony_rx,
  output ssm_unit_rx_s sync_rx,
  output ssm_mode_e mode
);

  // reset release pair
  logic rst_meta;
  logic rst_sync_n;
  // raw pad levels and their two stage synchronised copies
  logic [3:0] pad_raw;
  logic [3:0] pad_meta;
  logic [3:0] pad_sync;
  // select decode ahead of the mode register
  ssm_mode_e next_mode;

  // reset release through two flops so the mux leaves reset on a clean edge;
  // assertion stays asynchronous so pads let go even without a clock
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // pad order within the synchroniser: clock, rx data, tx frame, rx frame
  assign pad_raw = {rx_frame_pad_i, tx_frame_pad_i, rx_data_pad_i, bit_clock_pad_i};

  // pad inputs come from the far chip's clock domain: two flop synchroniser
  // per pad; only the second stage is read, the first may be metastable
  for (genvar p = 0; p < 4; p++) begin : g_pad_sync
    always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        pad_meta[p] <= 1'b1;
        pad_sync[p] <= 1'b1;
      end else begin
        pad_meta[p] <= pad_raw[p];
        pad_sync[p] <= pad_meta[p];
      end
    end
  end

  // select decode; codec port select wins so a stray serial select can
  // never pull the pads away from the multimedia port
  function automatic ssm_mode_e decode_mode(
    input logic cp_sel,
    input logic ser_sel
  );
    ssm_mode_e m;
    if (cp_sel) begin
      m = SSM_MODE_MM;
    end else if (ser_sel) begin
      m = SSM_MODE_TEL;
    end else begin
      m = SSM_MODE_SYNC;
    end
    return m;
  endfunction : decode_mode

  // next mode feeds both the pad drive and the mode register
  always_comb begin
    next_mode = decode_mode(codec_port_select_bit, serial_unit_select_bit);
  end

  // mode register; reset leaves the sync serial unit selected in slave role,
  // so nothing is driven onto clock or frames until the unit asks for it
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode <= SSM_MODE_SYNC;
    end else begin
      mode <= next_mode;
    end
  end

  // pad drive per mode; a switch hands the pads over in one edge with no
  // dead cycle, so far chips must tolerate the swap landing mid-frame
  function automatic ssm_pad_out_s drive_pads(
    input ssm_mode_e sel,
    input ssm_unit_tx_s mm,
    input ssm_unit_tx_s tel,
    input ssm_unit_tx_s sy,
    input ssm_sync_ctl_s ctl
  );
    ssm_pad_out_s p;
    p = '0;
    case (sel)
      SSM_MODE_MM: begin
        // sample clock on the tx frame pad; rx frame left to its pull-up
        p.clk_o = mm.bit_clock;
        p.clk_oe = 1'b1;
        p.txd_o = mm.data_out;
        p.txd_oe = 1'b1;
        p.txfr_o = mm.frame;
        p.txfr_oe = 1'b1;
        p.rxfr_oe = 1'b0;
      end
      SSM_MODE_TEL: begin
        // frame sync on the tx frame pad; rx frame left to its pull-up
        p.clk_o = tel.bit_clock;
        p.clk_oe = 1'b1;
        p.txd_o = tel.data_out;
        p.txd_oe = 1'b1;
        p.txfr_o = tel.frame;
        p.txfr_oe = 1'b1;
        p.rxfr_oe = 1'b0;
      end
      SSM_MODE_SYNC: begin
        // master drives clock and frames, slave leaves them to the far chip
        p.clk_o = sy.bit_clock;
        p.clk_oe = ctl.bit_clock_oe;
        p.txd_o = sy.data_out;
        p.txd_oe = 1'b1;
        p.txfr_o = sy.frame;
        p.txfr_oe = ctl.tx_frame_oe;
        p.rxfr_o = ctl.rx_frame;
        p.rxfr_oe = ctl.rx_frame_oe;
      end
      default: begin
        // unused encoding: release every pad
        p = '0;
      end
    endcase
    return p;
  endfunction : drive_pads

  // pad register: every pad output comes from a flop; it follows the
  // selects one edge later, in step with the mode register
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pads <= '0;
    end else begin
      pads <= drive_pads(next_mode, multimedia_tx, telephony_tx, sync_tx, sync_ctl);
    end
  end

  // receive view of one unit: idle-high unless that unit owns the pads;
  // only the sync unit takes clock and frames in from the pads (slave role)
  function automatic ssm_unit_rx_s route_rx(
    input ssm_mode_e cur,
    input ssm_mode_e unit,
    input logic [3:0] pin
  );
    ssm_unit_rx_s r;
    // unselected units read all ones so their receivers stay idle
    r = '1;
    if (cur == unit) begin
      r.data_in = pin[1];
      if (unit == SSM_MODE_SYNC) begin
        r.bit_clock = pin[0];
        r.tx_frame = pin[2];
        r.rx_frame = pin[3];
      end
    end
    return r;
  endfunction : route_rx

  // multimedia port receive; routed by the registered mode, so a unit
  // sees pad data one cycle after it has taken over the pad drive
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      multimedia_rx <= '1;
    end else begin
      multimedia_rx <= route_rx(mode, SSM_MODE_MM, pad_sync);
    end
  end

  // telephony codec receive
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      telephony_rx <= '1;
    end else begin
      telephony_rx <= route_rx(mode, SSM_MODE_TEL, pad_sync);
    end
  end

  // sync serial receive; in master role the pads echo this block's own
  // clock and frames back, which the unit may ignore
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync_rx <= '1;
    end else begin
      sync_rx <= route_rx(mode, SSM_MODE_SYNC, pad_sync);
    end
  end

endmodule : ssm_mux

// ==== sim/ssm_mux_checker.sv ====
// checker for the shared pad mux: pad routing and rx steering
// assumes ssm_mux ports only; bound after the module
`timescale 1ns/1ps
module ssm_mux_checker
  import ssm_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic serial_unit_select_bit,
  input wire logic codec_port_select_bit,
  input wire ssm_unit_tx_s multimedia_tx,
  input wire ssm_unit_tx_s telephony_tx,
  input wire ssm_unit_tx_s sync_tx,
  input wire ssm_sync_ctl_s sync_ctl,
  input wire logic rx_data_pad_i,
  input wire ssm_pad_out_s pads,
  input wire ssm_unit_rx_s telephony_rx,
  input wire ssm_unit_rx_s sync_rx,
  input wire ssm_mode_e mode
);
  logic [2:0] age;
  ssm_unit_tx_s pick;
  // edges since release; the 2-flop reset copy delays real output
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  always_comb pick = codec_port_select_bit ? multimedia_tx :
      serial_unit_select_bit ? telephony_tx : sync_tx;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n || age != 3'h7);
  // same mode on two edges, so rx routing has caught up
  sequence held(m);
    mode == m && $past(mode) == m;
  endsequence
  mode_pick_a: assert property (mode == ($past(codec_port_select_bit) ? SSM_MODE_MM :
      $past(serial_unit_select_bit) ? SSM_MODE_TEL : SSM_MODE_SYNC)) else $error("mode");
  txd_route_a: assert property (pads.txd_o == $past(pick.data_out)) else $error("txd");
  frame_route_a: assert property (mode != SSM_MODE_SYNC |-> pads.txfr_oe &&
      pads.txfr_o == $past(pick.frame)) else $error("txfr");
  clk_route_a: assert property (mode != SSM_MODE_SYNC |-> pads.clk_oe &&
      pads.clk_o == $past(pick.bit_clock)) else $error("clk");
  clk_role_a: assert property (mode == SSM_MODE_SYNC |-> pads.clk_oe ==
      $past(sync_ctl.bit_clock_oe) && pads.txfr_oe == $past(sync_ctl.tx_frame_oe)) else $error("role");
  rxfr_idle_a: assert property (mode != SSM_MODE_SYNC |-> !pads.rxfr_oe) else $error("rxfr");
  tel_rx_a: assert property (held(SSM_MODE_TEL) |-> telephony_rx.data_in ==
      $past(rx_data_pad_i, 3) && sync_rx == '1) else $error("tel rx");
  sync_rx_a: assert property (held(SSM_MODE_SYNC) |-> sync_rx.data_in ==
      $past(rx_data_pad_i, 3) && telephony_rx == '1) else $error("sync rx");
endmodule : ssm_mux_checker
bind ssm_mux ssm_mux_checker i_chk (.mclk, .reset_n, .serial_unit_select_bit,
  .codec_port_select_bit, .multimedia_tx, .telephony_tx, .sync_tx, .sync_ctl,
  .rx_data_pad_i, .pads, .telephony_rx, .sync_rx, .mode);

// ==== sim/ssm_codec_model.sv ====
// far-side codec: one byte a frame on an 800 ns link clock
// assumes run rises only between frames
`timescale 1ns/1ps
module ssm_codec_model (
  input wire logic run,
  output logic sck,
  output logic sdo,
  output logic fs
);
  localparam logic [7:0] WORD = 8'hA5;
  initial sck = 1'b0;
  initial sdo = 1'b1;
  initial fs = 1'b1;
  // slave role: clock and frame come from here; clock still between frames
  always @(posedge run) begin
    #37;
    for (int i = 7; i >= 0; i--) begin
      sdo = WORD[i];
      fs = (i != 7);
      #400 sck = 1'b1;
      #400 sck = 1'b0;
    end
    fs = 1'b1; // released frame line sits at its pull-up
    sdo = ~sdo; // released data shows the inverse, not a stale bit
  end
endmodule : ssm_codec_model

// ==== sim/tb_top.sv ====
// self-checking bench for the shared pad mux
// assumes ssm_mux, its checker and the codec model
`timescale 1ns/1ps
module tb_top;
  import ssm_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic cp_sel = 1'b0;
  logic ser_sel = 1'b0;
  logic run = 1'b0;
  ssm_sync_ctl_s ctl = '0;
  ssm_pad_out_s pads;
  ssm_unit_rx_s tel_rx, sync_rx, mm_rx;
  ssm_mode_e mode;
  logic sck, sdo, fs;
  int fail_count = 0;
  int tests_run = 0;
  // selects, sync controls, then mode and clk, clk_oe, txd, txfr, rxfr_oe
  logic [12:0] rows [5] = '{13'h107C, 13'h1FFC, 13'h0FAE, 13'h0789, 13'h0000};
  initial forever #50 mclk = ~mclk;
  ssm_codec_model i_peer (.run(run), .sck(sck), .sdo(sdo), .fs(fs));
  // unit outputs tied to distinct patterns so the clock, data and frame pads together show their source
  ssm_mux i_dut (.mclk(mclk), .reset_n(reset_n), .serial_unit_select_bit(ser_sel),
    .codec_port_select_bit(cp_sel), .multimedia_tx(3'h6), .telephony_tx(3'h3),
    .sync_tx(3'h0), .sync_ctl(ctl), .bit_clock_pad_i(pads.clk_oe ? pads.clk_o : sck),
    .rx_data_pad_i(sdo), .tx_frame_pad_i(pads.txfr_oe ? pads.txfr_o : fs),
    .rx_frame_pad_i(pads.rxfr_oe ? pads.rxfr_o : fs), .pads(pads), .multimedia_rx(mm_rx),
    .telephony_rx(tel_rx), .sync_rx(sync_rx), .mode(mode));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk
  task tally_and_finish;
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task wait_sck(input logic v);
    int k;
    for (k = 0; k < 20 && sck !== v; k++) @(negedge mclk);
    chk(8'(k < 20), 8'h01);
    if (k >= 20) tally_and_finish();
  endtask : wait_sck
  initial begin
    repeat (3) @(negedge mclk);
    chk(pads | 8'(mode), 8'h00);
    chk({tel_rx, sync_rx}, 8'hFF);
    chk(8'(mm_rx), 8'h0F);
    reset_n = 1'b1;
    repeat (6) @(negedge mclk);
    foreach (rows[i]) begin
      {cp_sel, ser_sel, ctl} = rows[i][12:7];
      @(negedge mclk);
      chk({mode, pads.clk_o, pads.clk_oe, pads.txd_o, pads.txfr_o, pads.rxfr_oe}, rows[i][6:0]);
    end
    // sync master: rx frame value, data and frame enables
    ctl = 4'hF;
    @(negedge mclk);
    chk({pads.rxfr_o, pads.txd_oe, pads.txfr_oe}, 8'h07);
    ctl = 4'h0;
    @(negedge mclk);
    // slave sync frame, then telephony frame, with the far side streaming
    for (int m = 0; m < 2; m++) begin
      ser_sel = 1'(m);
      run = 1'b1;
      for (int b = 0; b < 8; b++) begin
        wait_sck(1'b1);
        repeat (3) @(negedge mclk);
        if (m == 1) chk({tel_rx.data_in, sync_rx}, {sdo, 4'hF});
        else chk({sync_rx, tel_rx}, {1'b1, sdo, fs, fs, 4'hF});
        wait_sck(1'b0);
      end
      run = 1'b0;
      @(negedge mclk);
    end
    // multimedia port takes the rx data pad, the others go idle
    cp_sel = 1'b1;
    repeat (4) @(negedge mclk);
    chk({mm_rx, tel_rx.data_in, sync_rx.data_in}, {1'b1, sdo, 4'hF});
    tally_and_finish();
  end
endmodule : tb_top
